// ### complementary_wave_gen.sv
// Complementary waveform generator: steering, shutdown and dead-band
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module complementary_wave_gen (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire cwg_pkg::wbReq_type wbReq,
  output logic wbAck,
  output logic [31:0] wbDatOut,
  input wire logic [cwg_pkg::SRC_COUNT-1:0] srcIn,
  input wire logic fastOscIn,
  output cwg_pkg::pinOut_type pins
);
  import cwg_pkg::*;

  logic enable;
  logic [2:0] mode;
  logic [3:0] invert;
  logic waveClkSel;
  logic [3:0] dataSrcSel;
  logic [3:0] steerEn;
  logic [3:0] overrideVal;
  logic [3:0] steerAct;
  logic [3:0] steerUse;
  logic shutdown;
  logic shutPrev;
  logic restartEn;
  logic [1:0] haltLevelBd;
  logic [1:0] haltLevelAc;
  logic [4:0] haltSrcEn;
  logic [5:0] riseGapCount;
  logic [5:0] fallGapCount;
  logic [SRC_COUNT-1:0] srcMeta;
  logic [SRC_COUNT-1:0] srcSync;
  logic oscMeta;
  logic oscSync;
  logic oscPrev;
  logic tick;
  logic dataIn;
  logic dataPrev;
  logic dataRise;
  logic [4:0] haltSources;
  logic haltReq;
  logic holdOff;
  logic halted;
  logic [5:0] haltWait;
  logic haltDone;
  logic riseLvl;
  logic fallLvl;
  logic [5:0] riseCnt;
  logic [5:0] fallCnt;
  logic wbHit;
  logic wbWr;
  logic [7:0] wrData;
  logic [7:0] rdByte;
  logic steerRef;
  pinOut_type nextPins;

  // Dead-band step: rise of target delayed, fall passes at once
  function automatic logic [6:0] gapStep(
    input logic target,
    input logic level,
    input logic [5:0] cnt,
    input logic [5:0] limit,
    input logic tk
  );
    logic [6:0] res;
    res = {level, 6'h00};
    if (!target) begin
      res = {1'b0, 6'h00};
    end else if (!level) begin
      if (limit == 6'h00) begin
        res = {1'b1, 6'h00};
      end else if (tk && cnt == limit) begin
        res = {1'b1, 6'h00};
      end else if (tk) begin
        res = {1'b0, cnt + 6'h01};
      end else begin
        res = {1'b0, cnt};
      end
    end
    return res;
  endfunction : gapStep

  // Shutdown pin state as {oe, out}
  function automatic logic [1:0] haltPin(
    input logic [1:0] lvl,
    input logic inv,
    input logic done,
    input logic [1:0] now
  );
    logic [1:0] res;
    res = now;
    unique case (lvl)
      HALT_HIGH: res = 2'h3;
      HALT_LOW: res = 2'h2;
      HALT_FLOAT: res = 2'h0;
      HALT_INACTIVE: res = done ? {1'b1, inv} : now;
    endcase
    return res;
  endfunction : haltPin

  // Every source is asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      srcMeta <= '0;
      srcSync <= '0;
      oscMeta <= 1'b0;
      oscSync <= 1'b0;
      oscPrev <= 1'b0;
      dataPrev <= 1'b0;
    end else begin
      srcMeta <= srcIn;
      srcSync <= srcMeta;
      oscMeta <= fastOscIn;
      oscSync <= oscMeta;
      oscPrev <= oscSync;
      dataPrev <= dataIn;
    end
  end

  // Fast oscillator counts only its sampled rising edges
  assign tick = waveClkSel ? (oscSync & ~oscPrev) : 1'b1;
  assign dataIn = (dataSrcSel < 4'(SRC_COUNT)) ? srcSync[dataSrcSel] : 1'b0;
  assign dataRise = dataIn & ~dataPrev;
  assign haltSources = {srcSync[SRC_LOGIC_CELL_FOUR], srcSync[SRC_LOGIC_CELL_TWO],
                        srcSync[SRC_CMP2], srcSync[SRC_CMP1],
                        srcSync[SRC_PIN]};
  assign haltReq = |(haltSources & haltSrcEn);
  assign halted = shutdown | holdOff;
  assign haltDone = (haltWait == 6'h00) && !(shutdown && !shutPrev);
  assign steerUse = (mode == MODE_SYNC_STEER) ? steerAct : steerEn;
  assign steerRef = dataIn ^ invert[0];

  // Bus slave: one wait state, unmapped reads return zero
  assign wbHit = wbReq.cyc & wbReq.stb & ~wbAck;
  assign wbWr = wbHit & wbReq.we & wbReq.sel[0];
  assign wrData = wbReq.dat[7:0];

  always_comb begin
    rdByte = 8'h00;
    unique case (wbReq.adr)
      OFS_CONTROL: rdByte = {enable, 4'h0, mode};
      OFS_POLARITY: rdByte = {2'h0, dataIn, 1'b0, invert};
      OFS_CLOCK: rdByte = {7'h00, waveClkSel};
      OFS_DATA: rdByte = {4'h0, dataSrcSel};
      OFS_STEER: rdByte = {overrideVal, steerEn};
      OFS_HALT_CTL: rdByte = {shutdown, restartEn, haltLevelBd,
                              haltLevelAc, 2'h0};
      OFS_HALT_SRC: rdByte = {3'h0, haltSrcEn};
      OFS_RISE_GAP: rdByte = {2'h0, riseGapCount};
      OFS_FALL_GAP: rdByte = {2'h0, fallGapCount};
      default: rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbAck <= 1'b0;
      wbDatOut <= 32'h0000_0000;
    end else begin
      wbAck <= wbHit;
      wbDatOut <= wbHit ? {24'h00_0000, rdByte} : 32'h0000_0000;
    end
  end

  // Plain configuration registers; upper bits are dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= 1'b0;
      mode <= MODE_ASYNC_STEER;
      invert <= 4'h0;
      waveClkSel <= 1'b0;
      dataSrcSel <= 4'h0;
      steerEn <= 4'h0;
      overrideVal <= 4'h0;
      haltSrcEn <= 5'h00;
      riseGapCount <= 6'h00;
      fallGapCount <= 6'h00;
    end else if (wbWr) begin
      unique case (wbReq.adr)
        OFS_CONTROL: begin
          enable <= wrData[EN_POS];
          mode <= wrData[2:0];
        end
        OFS_POLARITY: invert <= wrData[3:0];
        OFS_CLOCK: waveClkSel <= wrData[0];
        OFS_DATA: dataSrcSel <= wrData[3:0];
        OFS_STEER: begin
          overrideVal <= wrData[OVR_LSB +: 4];
          steerEn <= wrData[3:0];
        end
        OFS_HALT_SRC: haltSrcEn <= wrData[4:0];
        OFS_RISE_GAP: riseGapCount <= wrData[5:0];
        OFS_FALL_GAP: fallGapCount <= wrData[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      restartEn <= 1'b0;
      haltLevelBd <= RST_HALT_LEVEL;
      haltLevelAc <= RST_HALT_LEVEL;
    end else if (wbWr && wbReq.adr == OFS_HALT_CTL) begin
      restartEn <= wrData[REN_POS];
      haltLevelBd <= wrData[BD_LSB +: 2];
      haltLevelAc <= wrData[AC_LSB +: 2];
    end
  end

  // Set wins over any clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown <= 1'b0;
    end else if (haltReq) begin
      shutdown <= 1'b1;
    end else if (wbWr && wbReq.adr == OFS_HALT_CTL && !enable
                 && wrData[SD_POS]) begin
      shutdown <= 1'b1;
    end else if (restartEn) begin
      shutdown <= 1'b0;
    end else if (wbWr && wbReq.adr == OFS_HALT_CTL
                 && !wrData[SD_POS]) begin
      shutdown <= 1'b0;
    end
  end

  // Start-up also waits for a data rising edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdOff <= RST_HOLD;
      shutPrev <= 1'b0;
    end else begin
      shutPrev <= shutdown;
      if (shutdown) begin
        holdOff <= 1'b1;
      end else if (dataRise) begin
        holdOff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      haltWait <= 6'h00;
    end else if (shutdown && !shutPrev) begin
      haltWait <= riseGapCount;
    end else if (tick && haltWait != 6'h00) begin
      haltWait <= haltWait - 6'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      steerAct <= 4'h0;
    end else if (mode != MODE_SYNC_STEER || dataRise) begin
      steerAct <= steerEn;
    end
  end

  // Halting forces both paths low, so they restart from idle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {riseLvl, riseCnt} <= 7'h00;
      {fallLvl, fallCnt} <= 7'h00;
    end else begin
      {riseLvl, riseCnt} <= gapStep(dataIn & ~halted, riseLvl,
                                    riseCnt, riseGapCount, tick);
      {fallLvl, fallCnt} <= gapStep(~dataIn & ~halted, fallLvl,
                                    fallCnt, fallGapCount, tick);
    end
  end

  always_comb begin
    nextPins = '0;
    for (int i = 0; i < 4; i++) begin
      if (halted) begin
        {nextPins.oe[i], nextPins.out[i]} = haltPin(
          i[0] ? haltLevelBd : haltLevelAc, invert[i], haltDone,
          {pins.oe[i], pins.out[i]});
      end else if (enable) begin
        nextPins.oe[i] = 1'b1;
        if (mode[2:1] == 2'h0) begin
          nextPins.out[i] = steerUse[i] ? (dataIn ^ invert[i])
                                        : overrideVal[i];
        end else begin
          nextPins.out[i] = invert[i] ^ (i[0] ? fallLvl : riseLvl);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins <= '0;
    end else begin
      pins <= nextPins;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_run;
    enable && !halted;
  endsequence

  sequence s_cleared;
    $fell(shutdown) ##0 !dataRise;
  endsequence

  property p_steer_data;
    (s_run and mode == MODE_ASYNC_STEER && steerEn[0])
      |=> pins.out[0] == $past(steerRef) && pins.oe[0];
  endproperty
  a_steer_data: assert property (p_steer_data)
    else $error("steered output A not following data");

  property p_override;
    (s_run and mode == MODE_ASYNC_STEER && !steerEn[1])
      |=> pins.out[1] == $past(overrideVal[1]);
  endproperty
  a_override: assert property (p_override)
    else $error("override value not driven on B");

  property p_sync_buffer;
    (mode == MODE_SYNC_STEER && !dataRise) |=> $stable(steerAct);
  endproperty
  a_sync_buffer: assert property (p_sync_buffer)
    else $error("buffered steering changed without data edge");

  property p_set_wins;
    haltReq |=> shutdown;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("enabled source did not set shutdown");

  property p_auto_restart;
    (shutdown && restartEn && !haltReq && !wbWr) |=> !shutdown;
  endproperty
  a_auto_restart: assert property (p_auto_restart)
    else $error("auto restart did not clear shutdown");

  property p_hold_after;
    s_cleared |-> holdOff ##1 halted;
  endproperty
  a_hold_after: assert property (p_hold_after)
    else $error("outputs left shutdown before data edge");

  property p_halt_high;
    (halted && haltLevelAc == HALT_HIGH) |=> pins.out[0] && pins.oe[0];
  endproperty
  a_halt_high: assert property (p_halt_high)
    else $error("A not driven high in shutdown");

  property p_halt_float;
    (halted && haltLevelBd == HALT_FLOAT) |=> !pins.oe[1] && !pins.oe[3];
  endproperty
  a_halt_float: assert property (p_halt_float)
    else $error("B or D not floated in shutdown");

  property p_bypass;
    (riseGapCount == 6'h00 && dataIn && !halted) |=> riseLvl;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("zero dead-band did not bypass");

  property p_gap_two;
    ($rose(dataIn) && !waveClkSel && riseGapCount == 6'h02 && !halted
      && !riseLvl) ##1 (dataIn && !halted)[*2]
      |-> !riseLvl ##1 riseLvl;
  endproperty
  a_gap_two: assert property (p_gap_two)
    else $error("rising dead-band of two wrong length");

  property p_upper_zero;
    wbAck |-> wbDatOut[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unimplemented read bits not zero");

  property p_ack_pulse;
    wbAck |=> !wbAck;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

endmodule : complementary_wave_gen

// ### cwg_pkg.sv
// Constants and carrier types for the complementary waveform block
package cwg_pkg;

  // Synchronised source bus, indexed by data select code
  localparam int SRC_COUNT = 14;
  localparam int SRC_PIN = 0;
  localparam int SRC_CMP1 = 1;
  localparam int SRC_CMP2 = 2;
  localparam int SRC_LOGIC_CELL_TWO = 11;
  localparam int SRC_LOGIC_CELL_FOUR = 13;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_POLARITY = 8'h04;
  localparam logic [7:0] OFS_CLOCK = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_STEER = 8'h10;
  localparam logic [7:0] OFS_HALT_CTL = 8'h14;
  localparam logic [7:0] OFS_HALT_SRC = 8'h18;
  localparam logic [7:0] OFS_RISE_GAP = 8'h1C;
  localparam logic [7:0] OFS_FALL_GAP = 8'h20;

  // Field positions
  localparam int EN_POS = 7;
  localparam int IN_POS = 5;
  localparam int SD_POS = 7;
  localparam int REN_POS = 6;
  localparam int BD_LSB = 4;
  localparam int AC_LSB = 2;
  localparam int OVR_LSB = 4;

  // Modes and shutdown level codes
  localparam logic [2:0] MODE_ASYNC_STEER = 3'h0;
  localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
  localparam logic [1:0] HALT_INACTIVE = 2'h0;
  localparam logic [1:0] HALT_FLOAT = 2'h1;
  localparam logic [1:0] HALT_LOW = 2'h2;
  localparam logic [1:0] HALT_HIGH = 2'h3;

  // Reset values
  localparam logic [1:0] RST_HALT_LEVEL = HALT_FLOAT;
  localparam logic RST_HOLD = 1'b1;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wbReq_type;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } pinOut_type;

endpackage : cwg_pkg

// ### tb.sv
// Self-checking bench for the complementary waveform block
`timescale 1ns/1ps
`define CMP(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module tb;
  import cwg_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  wbReq_type wbReq = '0;
  logic wbAck;
  logic [31:0] wbDatOut;
  logic [SRC_COUNT-1:0] srcIn = '0;
  logic fastOscIn = 1'b0;
  pinOut_type pins;
  logic probe = 1'b0;
  logic [1:0] div = 2'h0;
  int miscompares = 0;
  int checked = 0;
  logic [31:0] readQ[$];
  logic [7:0] pinQ[$];
  logic [7:0] r;
  logic [3:0] pol;
  logic [3:0] e;
  logic d;
  int n;
  int c;
  int t;
  int hi;
  logic [7:0] tA[4] = '{OFS_CLOCK, OFS_DATA, OFS_HALT_SRC, OFS_RISE_GAP};
  logic [7:0] tM[4] = '{8'h01, 8'h0F, 8'h1F, 8'h3F};

  complementary_wave_gen dut_u (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wbReq(wbReq),
    .wbAck(wbAck),
    .wbDatOut(wbDatOut),
    .srcIn(srcIn),
    .fastOscIn(fastOscIn),
    .pins(pins)
  );

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Slow fast-oscillator stand-in: one rising edge every 8 cycles
  always @(posedge ref_clk) begin
    div <= div + 2'h1;
    if (div == 2'h3) fastOscIn <= ~fastOscIn;
  end

  // Settled values are compared at the falling edge
  always @(negedge ref_clk) begin
    logic [31:0] want;
    if (wbAck === 1'b1 && wbReq.we === 1'b0 && readQ.size() > 0) begin
      want = readQ.pop_front();
      `CMP(wbDatOut, want)
    end
    if (probe === 1'b1 && pinQ.size() > 0) begin
      want = {24'h0, pinQ.pop_front()};
      `CMP({24'h0, pins}, want)
    end
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
    int k;
    k = 0;
    wbReq <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, v}};
    do begin
      @(negedge ref_clk);
      k++;
    end while (wbAck !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      tally_and_finish();
    end else begin
      @(posedge ref_clk);
      wbReq <= '0;
      @(posedge ref_clk);
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    wb(1'b1, a, v);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    readQ.push_back({24'h0, v});
    wb(1'b0, a, 8'h00);
  endtask : rd

  task automatic idle(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : idle

  task automatic checkPins(input logic [3:0] o, input logic [3:0] en);
    pinQ.push_back({o, en});
    probe <= 1'b1;
    @(posedge ref_clk);
    probe <= 1'b0;
  endtask : checkPins

  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(97));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_HALT_CTL, 8'h14);
    rd(OFS_HALT_SRC, 8'h00);
    rd(8'h40, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(tA[i], 8'h00);
      wr(tA[i], 8'hFF);
      rd(tA[i], tM[i]);
      wr(tA[i], 8'h00);
    end
    // Every data select code, reserved ones read as low data
    for (int k = 0; k < 16; k++) begin
      wr(OFS_DATA, 8'(k));
      srcIn <= (k < 14) ? ~(14'h0001 << k) : '1;
      idle(4);
      rd(OFS_POLARITY, 8'h00);
      if (k < 14) begin
        srcIn <= 14'h0001 << k;
        idle(4);
        rd(OFS_POLARITY, 8'h20);
      end
    end
    wr(OFS_DATA, 8'h01);
    wr(OFS_CONTROL, 8'h80);
    srcIn <= 14'h0002;
    idle(4);
    srcIn <= 14'h0000;
    for (int j = 0; j < 6; j++) begin
      r = 8'($urandom);
      pol = 4'($urandom);
      d = 1'($urandom);
      wr(OFS_POLARITY, {4'h0, pol});
      wr(OFS_STEER, r);
      srcIn <= {12'h000, d, 1'b0};
      idle(5);
      for (int i = 0; i < 4; i++) e[i] = r[i] ? d ^ pol[i] : r[4+i];
      checkPins(e, 4'hF);
    end
    // Overrides ignored outside the steering modes
    wr(OFS_POLARITY, 8'h00);
    wr(OFS_STEER, 8'hF0);
    srcIn <= 14'h0002;
    wr(OFS_CONTROL, 8'h84);
    idle(8);
    checkPins(4'h5, 4'hF);
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_STEER, 8'h00);
    wr(OFS_CONTROL, 8'h81);
    wr(OFS_STEER, 8'h0F);
    idle(5);
    checkPins(4'h0, 4'hF);
    srcIn <= 14'h0000;
    idle(4);
    srcIn <= 14'h0002;
    idle(5);
    checkPins(4'hF, 4'hF);
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_HALT_CTL, 8'h38);
    wr(OFS_HALT_SRC, 8'h01);
    srcIn <= 14'h0003;
    idle(5);
    checkPins(4'hA, 4'hF);
    rd(OFS_HALT_CTL, 8'hB8);
    wr(OFS_HALT_CTL, 8'h38);
    rd(OFS_HALT_CTL, 8'hB8);
    srcIn <= 14'h0002;
    idle(4);
    wr(OFS_HALT_CTL, 8'h38);
    rd(OFS_HALT_CTL, 8'h38);
    idle(4);
    checkPins(4'hA, 4'hF);
    srcIn <= 14'h0000;
    idle(4);
    srcIn <= 14'h0002;
    idle(5);
    checkPins(4'hF, 4'hF);
    wr(OFS_HALT_CTL, 8'h78);
    srcIn <= 14'h0003;
    idle(5);
    rd(OFS_HALT_CTL, 8'hF8);
    srcIn <= 14'h0002;
    idle(5);
    rd(OFS_HALT_CTL, 8'h78);
    wr(OFS_HALT_SRC, 8'h00);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_HALT_CTL, 8'hBC);
    idle(4);
    checkPins(4'hF, 4'hF);
    rd(OFS_HALT_CTL, 8'hBC);
    wr(OFS_HALT_CTL, 8'h3C);
    srcIn <= 14'h0000;
    idle(4);
    srcIn <= 14'h0002;
    idle(4);
    // Rising gap on A and falling gap on B, half-bridge mode
    for (int j = 0; j < 4; j++) begin
      n = (j == 0) ? 0 : (j == 1) ? 5 : 2;
      t = (j == 2) ? 8 : 1;
      hi = (n == 0) ? 5 : 6 + (n + 2) * t;
      srcIn <= 14'h0000;
      wr(OFS_CLOCK, 8'(j == 2));
      wr(OFS_RISE_GAP, 8'(n));
      wr(OFS_FALL_GAP, 8'(n));
      wr(OFS_CONTROL, 8'h84);
      idle(60);
      for (int s = 0; s < 2; s++) begin
        srcIn <= {12'h000, s == 0, 1'b0};
        c = 0;
        do begin
          @(negedge ref_clk);
          c++;
        end while (pins.out[s] !== 1'b1 && c < 900);
        `CMP(c >= 3 + n * t && c <= hi, 1'b1)
        @(posedge ref_clk);
      end
    end
    // B and D float; A and C hold, then go inactive after the gap
    wr(OFS_HALT_CTL, 8'h10);
    wr(OFS_POLARITY, 8'h01);
    wr(OFS_HALT_SRC, 8'h01);
    srcIn <= 14'h0002;
    idle(8);
    srcIn <= 14'h0003;
    idle(5);
    checkPins(4'h4, 4'h5);
    idle(2);
    checkPins(4'h1, 4'h5);
    idle(4);
    tally_and_finish();
  end
endmodule : tb
